// *** src/sac_pkg.sv ***
package sac_pkg;

	// Attenuation and address word layout
	localparam int ATT_W = 7;
	localparam int WORD_W = 8;
	localparam int ADDR_W = 3;
	localparam int SR_W = 2 * WORD_W;
	localparam int ATT_POS = 0;
	localparam int ADDR_POS = WORD_W;
	localparam int BIT_CNT_W = 5;

	// Power-up values
	localparam logic [ATT_W-1:0] ATT_MAX = 7'h7F;
	localparam logic [WORD_W-1:0] ADDR_WORD_RESET = 8'h00;
	localparam logic [SR_W-1:0] SR_RESET = 16'h007F;

	// Timing of the host end
	localparam int CLK_PERIOD_NS = 40;
	localparam int SCLK_HALF_NS = 160;
	localparam int MODE_SETUP_NS = 100;
	localparam int SWITCH_GAP_NS = 40000;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MODE_SETUP_CYC = (MODE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SWITCH_GAP_CYC = (SWITCH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 11;

	// Register map of the host end
	localparam int AXI_AW = 4;
	localparam logic [AXI_AW-1:0] REG_CMD = 4'h0;
	localparam logic [AXI_AW-1:0] REG_STATUS = 4'h4;
	localparam int CMD_ATT_LSB = 0;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CMD_MODE_LSB = 12;
	localparam int STAT_BUSY_BIT = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [3:0] STRB_NEEDED = 4'h3;

	typedef enum logic [1:0] {
		MODE_SERIAL = 2'b00,
		MODE_LATCHED = 2'b01,
		MODE_DIRECT = 2'b10
	} sac_mode_t;

	typedef enum logic [2:0] {
		HS_IDLE = 3'b000,
		HS_SETUP = 3'b001,
		HS_LOW = 3'b010,
		HS_HIGH = 3'b011,
		HS_LATCH = 3'b100,
		HS_GAP = 3'b101
	} sac_hstate_t;

endpackage

// *** src/sac_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface sac_if;
	import sac_pkg::*;

	logic serial_clock;
	logic serial_data;
	logic load_strobe;
	logic select_drive;
	logic select_drive_oe;
	logic interface_select;
	logic [ATT_W-1:0] attenuation_control_bits;

	// Undriven select pin floats high through its pull-up
	assign interface_select = select_drive_oe ? select_drive : 1'h1;

	modport host (
		output serial_clock,
		output serial_data,
		output load_strobe,
		output select_drive,
		output select_drive_oe,
		output attenuation_control_bits
	);

	modport dev (
		input serial_clock,
		input serial_data,
		input load_strobe,
		input interface_select,
		input attenuation_control_bits
	);

endinterface

`default_nettype wire

// *** src/sac_device.sv ***
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Select high or floating picks serial mode
// - Serial bits fill a 16-bit shift register
// - Attenuation word first, then the address word
// - Three address bits must match board pins
// - Unconnected board pins read as address 000
// - Address mismatch leaves attenuation unchanged
// - Eight devices share data, clock and strobe
// - Upper five address bits are ignored
// - Binary weighted word, spare bit ignored
// - A one bit inserts its attenuation section
// - Power-up gives maximum attenuation, address 000
// - Strobe rising edge copies words to active
// - LSB first, one bit per clock rise
// - Strobe high freezes the shift register
// - Host keeps strobe high when idle
// - Host spaces state changes 40 us apart
// - Direct parallel follows the control bits
// - Latched parallel holds while strobe low
// - Strobe rise adopts presented parallel bits
// - Latched power-up stays at maximum attenuation
// - Parallel bits use the same weighting
// - Parallel bits ignored in serial mode
module sac_device
	import sac_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clk_en,
	sac_if.dev link,
	input wire logic [ADDR_W-1:0] board_address_pins,
	input wire logic [ADDR_W-1:0] board_address_driven,
	output logic [ATT_W-1:0] atten_state,
	output logic [WORD_W-1:0] address_word,
	output logic serial_mode,
	output logic load_rejected,
	output logic [BIT_CNT_W-1:0] bits_shifted
);

	// Pins plus the connection flags of the board address pins
	localparam int SYNC_W = 4 + ATT_W + 2 * ADDR_W;
	// Idle pattern: strobe high and select high so no false edge at release
	localparam logic [SYNC_W-1:0] SYNC_IDLE = {1'h0, 1'h0, 1'h1, 1'h1,
		{ATT_W{1'h0}}, {ADDR_W{1'h0}}, {ADDR_W{1'h0}}};
	localparam logic [BIT_CNT_W-1:0] BIT_FULL = BIT_CNT_W'(SR_W);
	localparam logic [BIT_CNT_W-1:0] BIT_ONE = 5'h01;
	localparam logic [BIT_CNT_W-1:0] BIT_NONE = 5'h00;

	// Synchronised pins and their edges
	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] meta_ff;
	logic [SYNC_W-1:0] sync_ff;
	logic sclk_s;
	logic sdata_s;
	logic strobe_s;
	logic select_s;
	logic [ATT_W-1:0] par_s;
	logic [ADDR_W-1:0] board_lvl_s;
	logic [ADDR_W-1:0] board_drv_s;
	logic [ADDR_W-1:0] board_s;
	logic sclk_prev_ff;
	logic strobe_prev_ff;
	logic sclk_rise;
	logic strobe_rise;
	// Decoded shift and load conditions
	logic shift_en;
	logic ser_load;
	logic ser_hit;
	logic par_load;
	// Registers and their next values
	logic [SR_W-1:0] sr_ff;
	logic [SR_W-1:0] nxt_sr;
	logic [ATT_W-1:0] atten_ff;
	logic [ATT_W-1:0] nxt_atten;
	logic [WORD_W-1:0] addr_word_ff;
	logic [WORD_W-1:0] nxt_addr_word;
	logic rejected_ff;
	logic nxt_rejected;
	logic [BIT_CNT_W-1:0] bits_ff;
	logic [BIT_CNT_W-1:0] nxt_bits;
	logic [ATT_W-1:0] ser_att;
	logic [WORD_W-1:0] ser_addr_word;
	logic [ADDR_W-1:0] ser_addr;
	logic ser_take;

	// Every pin crosses into ref_clk through two flops before use
	assign pins_raw = {link.serial_clock, link.serial_data, link.load_strobe,
		link.interface_select, link.attenuation_control_bits,
		board_address_pins, board_address_driven};

	// Two-flop synchroniser for all pins
	// Strobe and select reset to their idle level, so the edge
	// detectors below see no false rise when reset lets go
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			meta_ff <= SYNC_IDLE;
			sync_ff <= SYNC_IDLE;
		end else if (clk_en) begin
			meta_ff <= pins_raw;
			sync_ff <= meta_ff;
		end
	end

	// Unpack the synchronised pins
	assign {sclk_s, sdata_s, strobe_s, select_s, par_s, board_lvl_s, board_drv_s} = sync_ff;

	// Unconnected address pins read zero through their pull-downs
	assign board_s = board_lvl_s & board_drv_s;

	// Edge history of serial clock and strobe
	// Reset values match the idle pins: clock low, strobe high
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sclk_prev_ff <= 1'h0;
			strobe_prev_ff <= 1'h1;
		end else if (clk_en) begin
			sclk_prev_ff <= sclk_s;
			strobe_prev_ff <= strobe_s;
		end
	end

	// Edge detection
	assign sclk_rise = sclk_s & ~sclk_prev_ff;
	assign strobe_rise = strobe_s & ~strobe_prev_ff;

	// Shifting only in serial mode and only while strobe is low
	assign shift_en = select_s & ~strobe_s & sclk_rise;

	// New bits enter at the top, so the first bit ends at bit 0
	assign nxt_sr = shift_en ? {sdata_s, sr_ff[SR_W-1:1]} : sr_ff;

	// Bits taken since the last load, saturating at a full frame
	// A longer frame only pushes the oldest bits out of the register
	assign nxt_bits = strobe_rise ? BIT_NONE :
		(shift_en && bits_ff != BIT_FULL) ? bits_ff + BIT_ONE : bits_ff;

	// Fields of the received frame
	assign ser_att = sr_ff[ATT_POS +: ATT_W];
	assign ser_addr_word = sr_ff[ADDR_POS +: WORD_W];
	assign ser_addr = ser_addr_word[ADDR_W-1:0];

	// Board address compare on the three low address bits only
	assign ser_hit = (ser_addr == board_s);

	// Serial transfer happens on the strobe rising edge
	assign ser_load = select_s & strobe_rise;

	// A serial load reaches the active register only for this board's address
	assign ser_take = ser_load & ser_hit;

	// Parallel bits load while strobe is high: direct follows, latched
	// adopts at the rise; serial mode never looks at them
	assign par_load = ~select_s & strobe_s;

	// Single source for the attenuator setting
	// Parallel bits win while select is low; serial only on a match
	assign nxt_atten = par_load ? par_s :
		ser_take ? ser_att : atten_ff;

	// Stored address word follows successful serial loads
	assign nxt_addr_word = ser_take ? ser_addr_word : addr_word_ff;

	// Last serial load refused for a foreign address
	// Parallel loads leave the flag as the last serial load set it
	assign nxt_rejected = ser_load ? ~ser_hit : rejected_ff;

	// Shift register and frame counter
	// The frame stays after a load; the next frame pushes it out
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sr_ff <= SR_RESET;
			bits_ff <= BIT_NONE;
		end else if (clk_en) begin
			sr_ff <= nxt_sr;
			bits_ff <= nxt_bits;
		end
	end

	// Active state starts at maximum, mode switches do not touch it
	// Clock enable low freezes it together with everything else
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			atten_ff <= ATT_MAX;
			addr_word_ff <= ADDR_WORD_RESET;
			rejected_ff <= 1'h0;
		end else if (clk_en) begin
			atten_ff <= nxt_atten;
			addr_word_ff <= nxt_addr_word;
			rejected_ff <= nxt_rejected;
		end
	end

	// Each high bit switches its section in
	assign atten_state = atten_ff;

	// Status taps for software and the checker
	assign address_word = addr_word_ff;
	assign serial_mode = select_s;
	assign load_rejected = rejected_ff;
	assign bits_shifted = bits_ff;

endmodule

`default_nettype wire

// *** src/sac_host.sv ***
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module sac_host
	import sac_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	sac_if.host link
);

	localparam logic [CNT_W-1:0] HALF = CNT_W'(SCLK_HALF_CYC);
	localparam logic [CNT_W-1:0] SETUP = CNT_W'(MODE_SETUP_CYC);
	localparam logic [CNT_W-1:0] GAP = CNT_W'(SWITCH_GAP_CYC);
	localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
	localparam logic [3:0] LAST_BIT = 4'(SR_W - 1);

	logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
	logic [AXI_AW-1:0] awaddr_ff;
	logic [31:0] wdata_ff, cmd_ff, rdata_ff;
	logic [3:0] wstrb_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic wr_fire, cmd_ok, rd_take;
	logic [31:0] rd_word;
	sac_mode_t cmd_mode, mode_ff, nxt_mode;
	sac_hstate_t state_ff, nxt_state;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [3:0] bit_ff, nxt_bit;
	logic [SR_W-1:0] word_ff, nxt_word;
	logic sclk_ff, nxt_sclk, sdata_ff, nxt_sdata, le_ff, nxt_le;
	logic sel_ff, nxt_sel, sel_oe_ff, nxt_sel_oe;
	logic [ATT_W-1:0] par_ff, nxt_par;
	logic cnt_done;

	// Bus handshakes and command decode
	assign s_axi_awready = clk_en & ~aw_got_ff;
	assign s_axi_wready = clk_en & ~w_got_ff;
	assign s_axi_arready = clk_en & ~rvalid_ff;
	assign wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
	assign rd_take = s_axi_arvalid & s_axi_arready;
	assign cmd_mode = sac_mode_t'(wdata_ff[CMD_MODE_LSB +: 2]);
	assign cmd_ok = wr_fire && awaddr_ff == REG_CMD && state_ff == HS_IDLE &&
		cmd_mode != 2'h3 && (wstrb_ff & STRB_NEEDED) == STRB_NEEDED;
	assign rd_word = (s_axi_araddr == REG_STATUS) ?
		32'(state_ff != HS_IDLE) << STAT_BUSY_BIT : cmd_ff;

	// Write channel
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			aw_got_ff <= 1'h0;
			w_got_ff <= 1'h0;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
			bvalid_ff <= 1'h0;
			bresp_ff <= RESP_OKAY;
			cmd_ff <= '0;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_ff <= 1'h1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_ff <= 1'h1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_got_ff <= 1'h0;
				w_got_ff <= 1'h0;
				bvalid_ff <= 1'h1;
				bresp_ff <= cmd_ok ? RESP_OKAY : RESP_SLVERR;
				if (cmd_ok)
					cmd_ff <= wdata_ff;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'h0;
			end
		end
	end

	// Read channel
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rvalid_ff <= 1'h0;
			rdata_ff <= '0;
			rresp_ff <= RESP_OKAY;
		end else if (clk_en) begin
			if (rd_take) begin
				rvalid_ff <= 1'h1;
				rdata_ff <= rd_word;
				rresp_ff <= (s_axi_araddr == REG_STATUS || s_axi_araddr == REG_CMD) ?
					RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_ff && s_axi_rready) begin
				rvalid_ff <= 1'h0;
			end
		end
	end

	assign cnt_done = (cnt_ff == CNT_ONE);

	// Link sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_done ? cnt_ff : cnt_ff - CNT_ONE;
		nxt_bit = bit_ff;
		nxt_word = word_ff;
		nxt_mode = mode_ff;
		nxt_sclk = sclk_ff;
		nxt_sdata = sdata_ff;
		nxt_le = le_ff;
		nxt_sel = sel_ff;
		nxt_sel_oe = sel_oe_ff;
		nxt_par = par_ff;
		case (state_ff)
			HS_IDLE: begin
				nxt_le = 1'h1;
				if (cmd_ok) begin
					nxt_mode = cmd_mode;
					// Attenuation byte low, address byte high
					nxt_word = {{(WORD_W - ADDR_W){1'h0}},
						wdata_ff[CMD_ADDR_LSB +: ADDR_W], 1'h0,
						wdata_ff[CMD_ATT_LSB +: ATT_W]};
					nxt_sel_oe = (cmd_mode != MODE_SERIAL);
					nxt_sel = (cmd_mode == MODE_SERIAL);
					nxt_le = (cmd_mode == MODE_DIRECT);
					if (cmd_mode != MODE_SERIAL)
						nxt_par = wdata_ff[CMD_ATT_LSB +: ATT_W];
					nxt_bit = '0;
					nxt_cnt = SETUP;
					nxt_state = HS_SETUP;
				end
			end
			HS_SETUP: begin
				if (cnt_done) begin
					nxt_cnt = HALF;
					case (mode_ff)
						MODE_SERIAL: begin
							nxt_sdata = word_ff[0];
							nxt_state = HS_LOW;
						end
						MODE_LATCHED: nxt_state = HS_LATCH;
						default: begin
							nxt_cnt = GAP;
							nxt_state = HS_GAP;
						end
					endcase
				end
			end
			HS_LOW: begin
				if (cnt_done) begin
					nxt_sclk = 1'h1;
					nxt_cnt = HALF;
					nxt_state = HS_HIGH;
				end
			end
			HS_HIGH: begin
				if (cnt_done) begin
					nxt_sclk = 1'h0;
					nxt_cnt = HALF;
					if (bit_ff == LAST_BIT) begin
						nxt_state = HS_LATCH;
					end else begin
						nxt_bit = bit_ff + 4'h1;
						nxt_sdata = word_ff[bit_ff + 4'h1];
						nxt_state = HS_LOW;
					end
				end
			end
			HS_LATCH: begin
				if (cnt_done) begin
					nxt_le = 1'h1;
					nxt_cnt = GAP;
					nxt_state = HS_GAP;
				end
			end
			HS_GAP: begin
				if (cnt_done)
					nxt_state = HS_IDLE;
			end
			default: nxt_state = HS_IDLE;
		endcase
	end

	// Sequencer registers; strobe idles high and select floats
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_ff <= HS_IDLE;
			cnt_ff <= CNT_ONE;
			bit_ff <= '0;
			word_ff <= '0;
			mode_ff <= MODE_SERIAL;
			sclk_ff <= 1'h0;
			sdata_ff <= 1'h0;
			le_ff <= 1'h1;
			sel_ff <= 1'h1;
			sel_oe_ff <= 1'h0;
			par_ff <= '0;
		end else if (clk_en) begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			bit_ff <= nxt_bit;
			word_ff <= nxt_word;
			mode_ff <= nxt_mode;
			sclk_ff <= nxt_sclk;
			sdata_ff <= nxt_sdata;
			le_ff <= nxt_le;
			sel_ff <= nxt_sel;
			sel_oe_ff <= nxt_sel_oe;
			par_ff <= nxt_par;
		end
	end

	// Outputs
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign link.serial_clock = sclk_ff;
	assign link.serial_data = sdata_ff;
	assign link.load_strobe = le_ff;
	assign link.select_drive = sel_ff;
	assign link.select_drive_oe = sel_oe_ff;
	assign link.attenuation_control_bits = par_ff;

endmodule

`default_nettype wire

// *** testbench/sac_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none

module sac_assertions
	import sac_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic serial_clock,
	input wire logic serial_data,
	input wire logic load_strobe,
	input wire logic interface_select,
	input wire logic [ATT_W-1:0] attenuation_control_bits,
	input wire logic [ADDR_W-1:0] board_address_pins,
	input wire logic [ADDR_W-1:0] board_address_driven,
	input wire logic [ATT_W-1:0] atten_state,
	input wire logic serial_mode,
	input wire logic load_rejected,
	input wire logic [BIT_CNT_W-1:0] bits_shifted
);
	logic sclk_ff;
	logic strobe_ff;
	logic [SR_W-1:0] sr_ff;
	logic [CNT_W-1:0] gap_ff;
	wire shift_now;
	wire strobe_rise;
	wire addr_hit;
	wire [ADDR_W-1:0] own_addr;

	// Shift and address decode as the wire shows it
	assign shift_now = serial_clock && !sclk_ff && !load_strobe && interface_select;
	assign strobe_rise = load_strobe && !strobe_ff;
	assign own_addr = board_address_pins & board_address_driven;
	assign addr_hit = sr_ff[ADDR_POS +: ADDR_W] == own_addr;

	// Shadow shift register and cycles since last strobe rise
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sclk_ff <= 1'h0;
			strobe_ff <= 1'h1;
			sr_ff <= SR_RESET;
			gap_ff <= '1;
		end else begin
			sclk_ff <= serial_clock;
			strobe_ff <= load_strobe;
			if (shift_now) sr_ff <= {serial_data, sr_ff[SR_W-1:1]};
			if (strobe_rise) gap_ff <= '0;
			else if (gap_ff != '1) gap_ff <= gap_ff + 11'h001;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	property p_mode_sync; $stable(interface_select)[*3] |-> serial_mode == interface_select; endproperty
	property p_count; strobe_rise && interface_select |-> bits_shifted == 5'h10; endproperty
	property p_hit;
		strobe_rise && interface_select && addr_hit |->
			##4 atten_state == sr_ff[ATT_POS +: ATT_W] && !load_rejected;
	endproperty
	property p_miss;
		strobe_rise && interface_select && !addr_hit |->
			##4 load_rejected && atten_state == $past(atten_state, 4);
	endproperty
	property p_latched;
		strobe_rise && !interface_select |-> ##4 atten_state == $past(attenuation_control_bits, 4);
	endproperty
	property p_direct;
		(!interface_select && load_strobe && $stable(attenuation_control_bits))[*4]
			|-> atten_state == attenuation_control_bits;
	endproperty
	property p_hold; (!interface_select && !load_strobe)[*5] |-> $stable(atten_state); endproperty
	property p_no_shift; load_strobe[*5] |-> $stable(bits_shifted); endproperty
	property p_data_hold; serial_clock |-> $stable(serial_data); endproperty
	property p_gap; strobe_rise |-> gap_ff >= SWITCH_GAP_CYC - 1; endproperty
	property p_reset;
		$fell(reset) |-> atten_state == ATT_MAX && bits_shifted == 5'h00 && !load_rejected;
	endproperty

	a_mode_sync: assert property (p_mode_sync) else $error("mode flag off");
	a_count: assert property (p_count) else $error("shift count off");
	a_hit: assert property (p_hit) else $error("matching load lost");
	a_miss: assert property (p_miss) else $error("foreign load taken");
	a_latched: assert property (p_latched) else $error("latched load lost");
	a_direct: assert property (p_direct) else $error("direct not followed");
	a_hold: assert property (p_hold) else $error("state moved, strobe low");
	a_no_shift: assert property (p_no_shift) else $error("shift, strobe high");
	a_data_hold: assert property (p_data_hold) else $error("data moved, clock high");
	a_gap: assert property (p_gap) else $error("loads too close");
	a_reset: assert property (p_reset) else $error("bad reset state");

	// Main scenarios
	c_hit: cover property (strobe_rise && interface_select && addr_hit);
	c_miss: cover property (strobe_rise && interface_select && !addr_hit);
	c_latched: cover property (strobe_rise && !interface_select);
endmodule

`default_nettype wire

// *** testbench/step_attenuator_control_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module step_attenuator_control_port_tb
	import sac_pkg::*;
;
	logic ref_clk, reset, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, smode, rej;
	logic [AXI_AW-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rsp;
	logic [ADDR_W-1:0] board_pins, pin_used;
	logic [ATT_W-1:0] atten, w;
	logic [WORD_W-1:0] addr_word;
	logic [BIT_CNT_W-1:0] nbits;
	int n_mismatch, total_checks;

	sac_if link_if();

	sac_host i_sac_host (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .link(link_if));

	sac_device i_sac_device (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1), .link(link_if),
		.board_address_pins(board_pins), .board_address_driven(pin_used),
		.atten_state(atten), .address_word(addr_word), .serial_mode(smode),
		.load_rejected(rej), .bits_shifted(nbits));

	sac_assertions i_sac_assertions (.ref_clk(ref_clk), .reset(reset),
		.serial_clock(link_if.serial_clock), .serial_data(link_if.serial_data),
		.load_strobe(link_if.load_strobe), .interface_select(link_if.interface_select),
		.attenuation_control_bits(link_if.attenuation_control_bits),
		.board_address_pins(board_pins), .board_address_driven(pin_used),
		.atten_state(atten), .serial_mode(smode), .load_rejected(rej), .bits_shifted(nbits));

	// Clock
	always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Write: both channels offered, each dropped once taken
	task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw_t, w_t, b_t;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b_t = 1'b0;
		while (!b_t) begin
			@(negedge ref_clk);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = bvalid;
			rsp = bresp;
			@(posedge ref_clk);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rdr(input logic [AXI_AW-1:0] a);
		logic ar_t, r_t;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		r_t = 1'b0;
		while (!r_t) begin
			@(negedge ref_clk);
			ar_t = arvalid && arready;
			r_t = rvalid;
			rd = rdata;
			rsp = rresp;
			@(posedge ref_clk);
			if (ar_t) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		@(posedge ref_clk);
	endtask

	// Poll status until the sequencer is idle
	task automatic idle_wait;
		int n;
		n = 0;
		do begin
			rdr(REG_STATUS);
			n++;
		end while (rd[STAT_BUSY_BIT] !== 1'h0 && n < 3000);
		chk("status", rd, 32'h0);
	endtask

	// Command once idle, then wait until it has finished
	task automatic cmd(input logic [ATT_W-1:0] att, input logic [ADDR_W-1:0] adr,
		input sac_mode_t md);
		idle_wait();
		wr(REG_CMD, {18'h0, md, 1'h0, adr, 1'h0, att}, 4'hF);
		chk("bresp", rsp, RESP_OKAY);
		idle_wait();
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (60000) @(posedge ref_clk);
		n_mismatch++;
		end_sim();
	end

	initial begin
		{ref_clk, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		reset = 1'b1;
		board_pins = 3'h5;
		pin_used = 3'h7;
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		chk("atten", atten, ATT_MAX);
		chk("addr word", addr_word, ADDR_WORD_RESET);
		chk("mode", smode, 1'b1);
		// Matching serial load; a second command while busy is refused
		wr(REG_CMD, 32'h0000_0555, 4'hF);
		chk("bresp", rsp, RESP_OKAY);
		wr(REG_CMD, 32'h0000_0000, 4'hF);
		chk("busy bresp", rsp, RESP_SLVERR);
		idle_wait();
		chk("atten", atten, 7'h55);
		cmd(7'h3C, 3'h5, MODE_SERIAL);
		chk("atten", atten, 7'h3C);
		chk("addr word", addr_word, 8'h05);
		chk("bits", nbits, 5'h00);
		// Foreign address leaves state
		cmd(7'h2A, 3'h4, MODE_SERIAL);
		chk("atten", atten, 7'h3C);
		chk("addr word", addr_word, 8'h05);
		chk("rejected", rej, 1'h1);
		// Unconnected pins read as zero
		pin_used <= 3'h2;
		cmd(7'h11, 3'h0, MODE_SERIAL);
		chk("atten", atten, 7'h11);
		chk("rejected", rej, 1'b0);
		cmd(7'h22, 3'h5, MODE_SERIAL);
		chk("atten", atten, 7'h11);
		// Latched parallel
		cmd(7'h0F, 3'h0, MODE_LATCHED);
		chk("atten", atten, 7'h0F);
		chk("mode", smode, 1'b0);
		// Direct parallel: each weight, then all ones
		for (int i = 0; i <= ATT_W; i++) begin
			w = (i == ATT_W) ? ATT_MAX : ATT_W'(1 << i);
			cmd(w, 3'h0, MODE_DIRECT);
			chk("direct", atten, w);
		end
		// Mode change to serial with a foreign address keeps state
		cmd(7'h05, 3'h7, MODE_SERIAL);
		chk("atten", atten, ATT_MAX);
		chk("mode", smode, 1'b1);
		// Refused accesses
		wr(REG_CMD, 32'h0000_3001, 4'hF);
		chk("mode 11", rsp, RESP_SLVERR);
		wr(REG_CMD, 32'h0000_0001, 4'h1);
		chk("strobe", rsp, RESP_SLVERR);
		wr(REG_STATUS, 32'h0, 4'hF);
		chk("ro write", rsp, RESP_SLVERR);
		rdr(4'h8);
		chk("unmapped", rsp, RESP_SLVERR);
		chk("last cmd", rd, 32'h0000_0705);
		chk("atten", atten, ATT_MAX);
		end_sim();
	end
endmodule

`default_nettype wire
